// >>> design/citf_defines.svh
`ifndef CITF_DEFINES_SVH
`define CITF_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define CITF_OFF_MODE 8'h00
`define CITF_OFF_FALL_CAP 8'h04
`define CITF_OFF_RISE_CAP 8'h08
`define CITF_OFF_CLK_STOP 8'h0C
`define CITF_OFF_PIN_FUNC 8'h10
`define CITF_OFF_IRQ 8'h14

// ****************************************************************
// reset values and field positions
// ****************************************************************
`define CITF_RST_MODE 8'h00
`define CITF_RST_CAP 8'h00
`define CITF_RST_CLK_STOP 8'hFF
`define CITF_RST_PIN_FUNC 2'h0
`define CITF_CLK_STOP_FIXED 8'hC0
`define CITF_STANDBY_BIT 3
`define CITF_PF_CAPTURE_BIT 0
`define CITF_PF_FILTER_BIT 1
`define CITF_IRQ_FLAG_BIT 0
`define CITF_IRQ_EN_BIT 1

// ****************************************************************
// divider taps and filter length
// ****************************************************************
`define CITF_PRE_W 6
`define CITF_TAP_DIV64 5
`define CITF_TAP_DIV32 4
`define CITF_TAP_DIV2 0
`define CITF_WDIV_W 2
`define CITF_FILT_LEN 5
`define CITF_CNT_MAX 8'hFF
`define CITF_CNT_ZERO 8'h00

`endif

// >>> design/citf_pkg.sv
`default_nettype none
package citf_pkg;

  typedef enum logic [1:0] {
    CITF_CKS_DIV64 = 2'b00,
    CITF_CKS_DIV32 = 2'b01,
    CITF_CKS_DIV2 = 2'b10,
    CITF_CKS_WATCH4 = 2'b11
  } citf_cks_t;

  typedef enum logic [1:0] {
    CITF_CLR_NONE = 2'b00,
    CITF_CLR_FALL = 2'b01,
    CITF_CLR_RISE = 2'b10,
    CITF_CLR_BOTH = 2'b11
  } citf_clr_t;

  typedef struct packed {
    logic overflow_high_flag;
    logic overflow_low_flag;
    logic overflow_interrupt_enable;
    logic interrupt_edge_select;
    citf_clr_t counter_clear_sel;
    citf_cks_t clock_select;
  } citf_mode_t;

  typedef struct packed {
    logic rise;
    logic fall;
  } citf_edge_t;

endpackage : citf_pkg
`default_nettype wire

// >>> design/citf_timer.sv
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "citf_defines.svh"

module citf_timer
  import citf_pkg::*;
#(
  parameter int CNT_W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic capture_pin,
  input wire logic watch_clk,
  output logic timer_irq
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function automatic logic addr_mapped(input logic [7:0] a);
    addr_mapped = (a == `CITF_OFF_MODE) || (a == `CITF_OFF_FALL_CAP) ||
                  (a == `CITF_OFF_RISE_CAP) || (a == `CITF_OFF_CLK_STOP) ||
                  (a == `CITF_OFF_PIN_FUNC) || (a == `CITF_OFF_IRQ);
  endfunction : addr_mapped

  function automatic logic all_equal(input logic [`CITF_FILT_LEN-1:0] v);
    all_equal = (&v) || (~|v);
  endfunction : all_equal

  // ****************************************************************
  // declarations
  // ****************************************************************
  citf_mode_t mode;
  citf_mode_t next_mode;
  logic [7:0] clk_stop;
  logic [7:0] next_clk_stop;
  logic [1:0] pin_func;
  logic [1:0] next_pin_func;
  logic irq_flag;
  logic next_irq_flag;
  logic irq_en;
  logic next_irq_en;
  logic [1:0] ovf_armed;
  logic [1:0] next_ovf_armed;
  logic [31:0] next_prdata;
  logic [`CITF_PRE_W-1:0] pre;
  logic [`CITF_PRE_W-1:0] next_pre;
  logic [`CITF_WDIV_W-1:0] wdiv;
  logic [`CITF_WDIV_W-1:0] next_wdiv;
  logic watch_q;
  logic clk_lvl;
  logic clk_lvl_q;
  logic sync1;
  logic sync2;
  logic [`CITF_FILT_LEN-1:0] filt_sh;
  logic [`CITF_FILT_LEN-1:0] next_filt_sh;
  logic filt_out;
  logic next_filt_out;
  logic filt_init;
  logic next_filt_init;
  logic sig;
  logic sig_q;
  logic next_sig_q;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [CNT_W-1:0] fall_cap;
  logic [CNT_W-1:0] next_fall_cap;
  logic [CNT_W-1:0] rise_cap;
  logic [CNT_W-1:0] next_rise_cap;
  logic running;
  logic cnt_tick;
  logic smp_tick;
  logic clr_hit;
  logic ovf_evt;
  logic ovf_high_set;
  logic ovf_low_set;
  logic edge_irq;
  logic wr_acc;
  logic rd_acc;
  logic rd_setup;
  citf_edge_t edges;

  // ****************************************************************
  // apb handshake
  // ****************************************************************
  assign pready = 1'b1;
  assign pslverr = psel && penable && !addr_mapped(paddr);
  assign wr_acc = psel && penable && pwrite && addr_mapped(paddr);
  assign rd_acc = psel && penable && !pwrite && (paddr == `CITF_OFF_MODE);
  assign rd_setup = psel && !penable && !pwrite;

  // read data is registered in the setup cycle; the counter is never mapped
  always_comb begin
    next_prdata = prdata;
    if (rd_setup) begin
      case (paddr)
        `CITF_OFF_MODE: next_prdata = {24'h0, mode};
        `CITF_OFF_FALL_CAP: next_prdata = 32'(fall_cap);
        `CITF_OFF_RISE_CAP: next_prdata = 32'(rise_cap);
        `CITF_OFF_CLK_STOP: next_prdata = {24'h0, clk_stop};
        `CITF_OFF_PIN_FUNC: next_prdata = {30'h0, pin_func};
        `CITF_OFF_IRQ: next_prdata = {30'h0, irq_en, irq_flag};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  // ****************************************************************
  // clock sources
  // ****************************************************************
  assign running = clk_stop[`CITF_STANDBY_BIT];

  always_comb begin
    next_pre = pre;
    next_wdiv = wdiv;
    if (running) begin
      next_pre = pre + `CITF_PRE_W'(1);
      if (watch_clk && !watch_q) begin
        next_wdiv = wdiv + `CITF_WDIV_W'(1);
      end
    end
    case (mode.clock_select)
      CITF_CKS_DIV64: clk_lvl = pre[`CITF_TAP_DIV64];
      CITF_CKS_DIV32: clk_lvl = pre[`CITF_TAP_DIV32];
      CITF_CKS_DIV2: clk_lvl = pre[`CITF_TAP_DIV2];
      CITF_CKS_WATCH4: clk_lvl = wdiv[`CITF_WDIV_W-1];
      default: clk_lvl = 1'b0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= '0;
      wdiv <= '0;
      watch_q <= 1'b0;
      clk_lvl_q <= 1'b0;
    end else begin
      pre <= next_pre;
      wdiv <= next_wdiv;
      watch_q <= watch_clk;
      clk_lvl_q <= clk_lvl;
    end
  end

  // counter steps on the falling edge of the selected clock
  assign cnt_tick = running && clk_lvl_q && !clk_lvl;
  assign smp_tick = running && (pin_func[`CITF_PF_FILTER_BIT] ? (clk_lvl && !clk_lvl_q) : 1'b1);

  // ****************************************************************
  // synchroniser and noise filter
  // ****************************************************************
  always_comb begin
    next_filt_sh = filt_sh;
    next_filt_out = filt_out;
    next_filt_init = filt_init;
    if (smp_tick) begin
      next_filt_sh = {filt_sh[`CITF_FILT_LEN-2:0], sync2};
      if (!filt_init && (~|next_filt_sh)) begin
        next_filt_init = 1'b1;
      end
      if ((filt_init || next_filt_init) && all_equal(next_filt_sh)) begin
        next_filt_out = next_filt_sh[0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
      filt_sh <= '1;
      filt_out <= 1'b0;
      filt_init <= 1'b0;
    end else begin
      sync1 <= capture_pin;
      sync2 <= sync1;
      filt_sh <= next_filt_sh;
      filt_out <= next_filt_out;
      filt_init <= next_filt_init;
    end
  end

  // ****************************************************************
  // edge detection
  // ****************************************************************
  // interval mode forces the signal low, so mode changes also make edges
  assign sig = pin_func[`CITF_PF_CAPTURE_BIT] &&
               (pin_func[`CITF_PF_FILTER_BIT] ? filt_out : sync2);

  always_comb begin
    next_sig_q = running ? sig : sig_q;
    edges.rise = running && sig && !sig_q;
    edges.fall = running && !sig && sig_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sig_q <= 1'b0;
    end else begin
      sig_q <= next_sig_q;
    end
  end

  // ****************************************************************
  // counter and capture registers
  // ****************************************************************
  always_comb begin
    case (mode.counter_clear_sel)
      CITF_CLR_NONE: clr_hit = 1'b0;
      CITF_CLR_FALL: clr_hit = edges.fall;
      CITF_CLR_RISE: clr_hit = edges.rise;
      CITF_CLR_BOTH: clr_hit = edges.rise || edges.fall;
      default: clr_hit = 1'b0;
    endcase
    ovf_evt = cnt_tick && !clr_hit && (cnt == CNT_W'(`CITF_CNT_MAX));
    ovf_high_set = ovf_evt && sig;
    ovf_low_set = ovf_evt && !sig;
    next_cnt = cnt;
    if (clr_hit) begin
      next_cnt = CNT_W'(`CITF_CNT_ZERO);
    end else if (cnt_tick) begin
      next_cnt = cnt + CNT_W'(1);
    end
    next_rise_cap = edges.rise ? cnt : rise_cap;
    next_fall_cap = edges.fall ? cnt : fall_cap;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= CNT_W'(`CITF_CNT_ZERO);
      rise_cap <= CNT_W'(`CITF_RST_CAP);
      fall_cap <= CNT_W'(`CITF_RST_CAP);
    end else begin
      cnt <= next_cnt;
      rise_cap <= next_rise_cap;
      fall_cap <= next_fall_cap;
    end
  end

  // ****************************************************************
  // control and status registers
  // ****************************************************************
  assign edge_irq = mode.interrupt_edge_select ? edges.fall : edges.rise;

  always_comb begin
    next_mode = mode;
    next_clk_stop = clk_stop;
    next_pin_func = pin_func;
    next_irq_en = irq_en;
    next_irq_flag = irq_flag;
    next_ovf_armed = ovf_armed;
    if (rd_acc) begin
      next_ovf_armed = ovf_armed | prdata[7:6];
    end
    if (wr_acc) begin
      case (paddr)
        `CITF_OFF_MODE: begin
          next_mode = citf_mode_t'(pwdata[7:0]);
          next_mode.overflow_high_flag = mode.overflow_high_flag &&
                                         !(ovf_armed[1] && !pwdata[7]);
          next_mode.overflow_low_flag = mode.overflow_low_flag &&
                                        !(ovf_armed[0] && !pwdata[6]);
          next_ovf_armed = 2'b00;
        end
        `CITF_OFF_CLK_STOP: next_clk_stop = pwdata[7:0] | `CITF_CLK_STOP_FIXED;
        `CITF_OFF_PIN_FUNC: next_pin_func = pwdata[1:0];
        `CITF_OFF_IRQ: begin
          next_irq_en = pwdata[`CITF_IRQ_EN_BIT];
          next_irq_flag = irq_flag && pwdata[`CITF_IRQ_FLAG_BIT];
        end
        default: next_mode = mode;
      endcase
    end
    // hardware sets win over software clears
    if (ovf_high_set) begin
      next_mode.overflow_high_flag = 1'b1;
    end
    if (ovf_low_set) begin
      next_mode.overflow_low_flag = 1'b1;
    end
    if (edge_irq || ((ovf_high_set || ovf_low_set) && mode.overflow_interrupt_enable)) begin
      next_irq_flag = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode <= citf_mode_t'(`CITF_RST_MODE);
      clk_stop <= `CITF_RST_CLK_STOP;
      pin_func <= `CITF_RST_PIN_FUNC;
      irq_en <= 1'b0;
      irq_flag <= 1'b0;
      ovf_armed <= 2'b00;
    end else begin
      mode <= next_mode;
      clk_stop <= next_clk_stop;
      pin_func <= next_pin_func;
      irq_en <= next_irq_en;
      irq_flag <= next_irq_flag;
      ovf_armed <= next_ovf_armed;
    end
  end

  assign timer_irq = irq_flag && irq_en;

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_standby_freeze: assert property (@(posedge pclk) disable iff (!presetn)
    !running |=> (cnt == $past(cnt)) && (rise_cap == $past(rise_cap)))
    else $error("counter moved in standby");

  chk_counter_step: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_tick && !clr_hit |=> cnt == CNT_W'($past(cnt) + CNT_W'(1)))
    else $error("counter did not step on tick");

  chk_counter_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (mode.counter_clear_sel == CITF_CLR_BOTH) && (edges.rise || edges.fall) |=> cnt == '0)
    else $error("counter not cleared on edge");

  chk_rise_capture: assert property (@(posedge pclk) disable iff (!presetn)
    edges.rise |=> (rise_cap == $past(cnt)) && (fall_cap == $past(fall_cap)))
    else $error("rising capture wrong");

  chk_fall_capture: assert property (@(posedge pclk) disable iff (!presetn)
    edges.fall |=> (fall_cap == $past(cnt)) && (rise_cap == $past(rise_cap)))
    else $error("falling capture wrong");

  chk_ovf_level: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_tick && !clr_hit && (cnt == CNT_W'(`CITF_CNT_MAX)) && !sig |=> mode.overflow_low_flag)
    else $error("low overflow flag not set");

  chk_ovf_high: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_evt && sig |=> mode.overflow_high_flag)
    else $error("high overflow flag not set");

  chk_edge_request: assert property (@(posedge pclk) disable iff (!presetn)
    edges.rise && !mode.interrupt_edge_select |=> irq_flag && (timer_irq == irq_en))
    else $error("rising edge request missing");

  chk_ovf_request: assert property (@(posedge pclk) disable iff (!presetn)
    ovf_evt && mode.overflow_interrupt_enable |=> irq_flag)
    else $error("overflow request missing");

  chk_filter_agree: assert property (@(posedge pclk) disable iff (!presetn)
    filt_out != $past(filt_out) |-> $past(smp_tick) && all_equal(filt_sh))
    else $error("filter changed without agreement");

  chk_flag_no_sw_set: assert property (@(posedge pclk) disable iff (!presetn)
    !mode.overflow_high_flag && !ovf_high_set |=> !mode.overflow_high_flag)
    else $error("high overflow flag set without overflow");

endmodule : citf_timer

`default_nettype wire

// >>> testbench/citf_pulse_src.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// external pulse source on the capture pin
// ****************************************************************
module citf_pulse_src (
  input wire logic pclk,
  output logic capture_pin
);
  initial begin
    capture_pin = 1'b0;
  end

  // holds a level for n system clocks, callers keep n >= 2
  task automatic drive(input logic level, input int n);
    @(posedge pclk);
    capture_pin <= level;
    repeat (n - 1) @(posedge pclk);
  endtask : drive
endmodule : citf_pulse_src
`default_nettype wire

// >>> testbench/citf_timer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "citf_defines.svh"
module citf_timer_tb_top;
  logic pclk;
  logic presetn;
  logic [7:0] paddr;
  logic psel;
  logic penable;
  logic pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic capture_pin;
  logic watch_clk;
  logic timer_irq;
  logic [3:0] wdiv = 4'h0;
  int err_count = 0;
  int checks_done = 0;
  int cycles = 0;
  logic [31:0] rd;
  logic [31:0] r0;
  logic er;

  citf_timer u_citf_timer (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .capture_pin(capture_pin), .watch_clk(watch_clk), .timer_irq(timer_irq)
  );
  citf_pulse_src u_citf_pulse_src (.pclk(pclk), .capture_pin(capture_pin));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  // watch clock: sixteen system clocks per period
  always @(posedge pclk) begin
    wdiv <= wdiv + 4'h1;
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      summarize();
    end
  end
  assign watch_clk = wdiv[3];

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task automatic summarize();
    if (err_count == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    checks_done++;
    if ($isunknown(got) || got < lo || got > hi) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= wr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e, e);
  endtask : rdchk

  task automatic irq_is(input logic e);
    @(negedge pclk);
    chk({31'h0, timer_irq}, {31'h0, e}, {31'h0, e});
  endtask : irq_is

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset();
    rdchk(`CITF_OFF_MODE, 32'h0);
    rdchk(`CITF_OFF_FALL_CAP, 32'h0);
    rdchk(`CITF_OFF_RISE_CAP, 32'h0);
    rdchk(`CITF_OFF_CLK_STOP, 32'hFF);
    rdchk(`CITF_OFF_PIN_FUNC, 32'h0);
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, er}, 32'h1, 32'h1);
    chk(rd, 32'h0, 32'h0);
    irq_is(1'b0);
  endtask : t_reset

  task automatic t_interval();
    int n;
    n = 0;
    wr(`CITF_OFF_IRQ, 32'h2);
    wr(`CITF_OFF_MODE, 32'h22);
    while (timer_irq !== 1'b1 && n < 700) begin
      @(posedge pclk);
      n++;
    end
    irq_is(1'b1);
    rdchk(`CITF_OFF_MODE, 32'h62);
    wr(`CITF_OFF_MODE, 32'h22);
    rdchk(`CITF_OFF_MODE, 32'h22);
    wr(`CITF_OFF_IRQ, 32'h2);
    irq_is(1'b0);
  endtask : t_interval

  task automatic t_clock();
    logic [31:0] e [4] = '{32'h4, 32'h8, 32'h80, 32'h4};
    wr(`CITF_OFF_PIN_FUNC, 32'h1);
    for (int i = 0; i < 4; i++) begin
      wr(`CITF_OFF_MODE, 32'h08 | i);
      u_citf_pulse_src.drive(1'b1, 256);
      u_citf_pulse_src.drive(1'b0, 12);
      apb(1'b0, `CITF_OFF_FALL_CAP, 32'h0);
      chk(rd, e[i] - 32'h1, e[i] + 32'h1);
    end
  endtask : t_clock

  task automatic t_edge_sel();
    wr(`CITF_OFF_MODE, 32'h12);
    wr(`CITF_OFF_IRQ, 32'h2);
    u_citf_pulse_src.drive(1'b1, 20);
    irq_is(1'b0);
    u_citf_pulse_src.drive(1'b0, 20);
    irq_is(1'b1);
    apb(1'b0, `CITF_OFF_RISE_CAP, 32'h0);
    r0 = rd;
    apb(1'b0, `CITF_OFF_FALL_CAP, 32'h0);
    chk({24'h0, rd[7:0] - r0[7:0]}, 32'h9, 32'hB);
  endtask : t_edge_sel

  task automatic t_clear();
    wr(`CITF_OFF_MODE, 32'h0E);
    u_citf_pulse_src.drive(1'b1, 20);
    u_citf_pulse_src.drive(1'b0, 40);
    u_citf_pulse_src.drive(1'b1, 20);
    apb(1'b0, `CITF_OFF_FALL_CAP, 32'h0);
    chk(rd, 32'h9, 32'hB);
    apb(1'b0, `CITF_OFF_RISE_CAP, 32'h0);
    chk(rd, 32'h13, 32'h15);
    wr(`CITF_OFF_MODE, 32'h06);
    u_citf_pulse_src.drive(1'b0, 30);
    u_citf_pulse_src.drive(1'b1, 10);
    apb(1'b0, `CITF_OFF_RISE_CAP, 32'h0);
    chk(rd, 32'hE, 32'h10);
    wr(`CITF_OFF_MODE, 32'h02);
    u_citf_pulse_src.drive(1'b1, 520);
    apb(1'b0, `CITF_OFF_MODE, 32'h0);
    chk({31'h0, rd[7]}, 32'h1, 32'h1);
    u_citf_pulse_src.drive(1'b0, 10);
  endtask : t_clear

  task automatic t_standby();
    wr(`CITF_OFF_CLK_STOP, 32'hF7);
    rdchk(`CITF_OFF_CLK_STOP, 32'hF7);
    apb(1'b0, `CITF_OFF_RISE_CAP, 32'h0);
    r0 = rd;
    u_citf_pulse_src.drive(1'b1, 20);
    u_citf_pulse_src.drive(1'b0, 20);
    rdchk(`CITF_OFF_RISE_CAP, r0);
    wr(`CITF_OFF_CLK_STOP, 32'hFF);
  endtask : t_standby

  task automatic t_switch();
    wr(`CITF_OFF_PIN_FUNC, 32'h0);
    wr(`CITF_OFF_MODE, 32'h02);
    u_citf_pulse_src.drive(1'b1, 4);
    wr(`CITF_OFF_IRQ, 32'h2);
    irq_is(1'b0);
    wr(`CITF_OFF_PIN_FUNC, 32'h1);
    repeat (4) @(posedge pclk);
    irq_is(1'b1);
    u_citf_pulse_src.drive(1'b0, 10);
  endtask : t_switch

  task automatic t_filter();
    wr(`CITF_OFF_PIN_FUNC, 32'h3);
    repeat (20) @(posedge pclk);
    wr(`CITF_OFF_IRQ, 32'h2);
    u_citf_pulse_src.drive(1'b1, 8);
    u_citf_pulse_src.drive(1'b0, 30);
    irq_is(1'b0);
    u_citf_pulse_src.drive(1'b1, 6);
    irq_is(1'b0);
    u_citf_pulse_src.drive(1'b1, 14);
    u_citf_pulse_src.drive(1'b0, 30);
    irq_is(1'b1);
  endtask : t_filter

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_interval();
    t_clock();
    t_edge_sel();
    t_clear();
    t_standby();
    t_switch();
    t_filter();
    summarize();
  end
endmodule : citf_timer_tb_top
`default_nettype wire
